//--- hdl/dpg_ctrl.sv
// controller end: refresh/port arbitration, grant flag, lock and row strobe timing
`timescale 1ns/1ps
`default_nettype none
module dpg_ctrl #(
  parameter logic [1:0] GRANT_LEAD = dpg_pkg::GRANT_LEAD_RST
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  dpg_if.ctrl bus,
  input wire logic refresh_req_i,
  output logic refresh_busy_o,
  output logic row_strobe_o,
  output logic [dpg_pkg::ROW_W-1:0] row_addr_o,
  output logic [dpg_pkg::COL_W-1:0] col_addr_o,
  output logic [dpg_pkg::BANK_W-1:0] bank_o,
  output logic [dpg_pkg::BYTE_W-1:0] byte_en_o,
  output logic write_o
);
  dpg_pkg::dpg_state_t state_q, state_d;
  logic grant_q, grant_d;
  logic [1:0] lead_q, lead_d;
  logic strobe_q, strobe_d;
  logic [dpg_pkg::ROW_W-1:0] row_q, row_d;
  logic [dpg_pkg::COL_W-1:0] col_q, col_d;
  logic [dpg_pkg::BANK_W-1:0] bank_q, bank_d;
  logic [dpg_pkg::BYTE_W-1:0] be_q, be_d;
  logic we_q, we_d;
  logic own_req, other_req;
  logic hand_over, lead_step, capture;

  // request of the granted and of the ungranted port
  assign own_req = grant_q ? bus.second_port_access_request : bus.first_port_access_request;
  assign other_req = grant_q ? bus.first_port_access_request : bus.second_port_access_request;

  // arbitration: refresh first, then the owner, the other port last
  always_comb begin
    state_d = state_q;
    hand_over = 1'h0;
    lead_step = 1'h0;
    unique case (state_q)
      dpg_pkg::DPG_IDLE: begin
        if (refresh_req_i) begin
          state_d = dpg_pkg::DPG_RFSH;
        end else if (own_req) begin
          state_d = dpg_pkg::DPG_ACC;
        end else if (other_req && !bus.lock) begin
          // owner idle and not locked: hand over, strobe follows later
          hand_over = 1'h1;
          state_d = dpg_pkg::DPG_LEAD;
        end
      end
      dpg_pkg::DPG_LEAD: begin
        // shared inputs are re-muxed during this gap by the port side
        if (refresh_req_i) begin
          state_d = dpg_pkg::DPG_RFSH;
        // a lead of zero acts as one
        end else if (lead_q <= 2'h1) begin
          state_d = own_req ? dpg_pkg::DPG_ACC : dpg_pkg::DPG_IDLE;
        end else begin
          lead_step = 1'h1;
        end
      end
      dpg_pkg::DPG_ACC: begin
        // ungranted port waits here regardless of lock
        if (!own_req) begin
          state_d = dpg_pkg::DPG_IDLE;
        end
      end
      dpg_pkg::DPG_RFSH: begin
        // lock never stalls refresh; grant stays as it was
        if (!refresh_req_i) begin
          state_d = dpg_pkg::DPG_IDLE;
        end
      end
      default: begin
        // a corrupted code falls back to idle, grant untouched
        state_d = dpg_pkg::DPG_IDLE;
      end
    endcase
  end

  // all state freezes while the clock enable is low
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= dpg_pkg::DPG_IDLE;
    end else if (clk_en_i) begin
      state_q <= state_d;
    end
  end

  // strobe is a register so the pin never glitches on a state decode
  always_comb begin
    strobe_d = 1'h0;
    if (state_d == dpg_pkg::DPG_ACC) begin
      strobe_d = 1'h1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_q <= 1'h0;
    end else if (clk_en_i) begin
      strobe_q <= strobe_d;
    end
  end

  // grant moves only on a hand-over, so refresh and lock leave it standing
  always_comb begin
    grant_d = grant_q;
    if (hand_over) begin
      grant_d = ~grant_q;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      grant_q <= dpg_pkg::GRANT_RST;
    end else if (clk_en_i) begin
      grant_q <= grant_d;
    end
  end

  // a longer lead gives slow port buffers time to settle before the strobe
  always_comb begin
    lead_d = lead_q;
    if (hand_over) begin
      lead_d = GRANT_LEAD;
    end else if (lead_step) begin
      lead_d = lead_q - 2'h1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lead_q <= 2'h0;
    end else if (clk_en_i) begin
      lead_q <= lead_d;
    end
  end

  // shared set is taken on the edge that raises the strobe; the port side
  // may re-mux it afterwards without disturbing the access under way
  assign capture = strobe_d && !strobe_q;

  always_comb begin
    row_d = row_q;
    col_d = col_q;
    bank_d = bank_q;
    be_d = be_q;
    we_d = we_q;
    // fields change only at the start of an access
    if (capture) begin
      row_d = bus.row_address_inputs;
      col_d = bus.column_address_inputs;
      bank_d = bus.bank_select_inputs;
      be_d = bus.byte_column_strobe_enables;
      we_d = bus.write_enable;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      row_q <= '0;
      col_q <= '0;
      bank_q <= '0;
      be_q <= '0;
      we_q <= 1'h0;
    end else if (clk_en_i) begin
      row_q <= row_d;
      col_q <= col_d;
      bank_q <= bank_d;
      be_q <= be_d;
      we_q <= we_d;
    end
  end

  // acks are combinational so they drop in the cycle the request falls
  assign bus.second_port_owner_flag = grant_q;
  assign bus.second_port_early_ack = strobe_q && grant_q && bus.second_port_access_request;
  assign bus.first_port_ack = strobe_q && !grant_q && bus.first_port_access_request;

  // data outputs come straight from the capture flops
  assign refresh_busy_o = (state_q == dpg_pkg::DPG_RFSH);
  assign row_strobe_o = strobe_q;
  assign row_addr_o = row_q;
  assign col_addr_o = col_q;
  assign bank_o = bank_q;
  assign byte_en_o = be_q;
  assign write_o = we_q;
endmodule
`default_nettype wire

//--- common/dpg_pkg.sv
// package: shared constants and types for the two-port grant lock
package dpg_pkg;
  localparam int unsigned ROW_W = 11;
  localparam int unsigned COL_W = 11;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned BYTE_W = 4;
  localparam logic GRANT_RST = 1'b0;
  // cycles from grant change to row strobe of the new access: 1 or 2
  localparam logic [1:0] GRANT_LEAD_MIN = 2'h1;
  localparam logic [1:0] GRANT_LEAD_MAX = 2'h2;
  localparam logic [1:0] GRANT_LEAD_RST = 2'h1;

  typedef enum logic [3:0] {
    DPG_IDLE = 4'h1,
    DPG_LEAD = 4'h2,
    DPG_ACC = 4'h4,
    DPG_RFSH = 4'h8
  } dpg_state_t;
endpackage

//--- common/dpg_if.sv
// interface: shared address/control set, requests, lock and grant between ports and controller
`timescale 1ns/1ps
`default_nettype none
interface dpg_if;
  logic first_port_access_request;
  logic second_port_access_request;
  logic lock;
  logic second_port_owner_flag;
  logic second_port_early_ack;
  logic first_port_ack;
  logic [dpg_pkg::ROW_W-1:0] row_address_inputs;
  logic [dpg_pkg::COL_W-1:0] column_address_inputs;
  logic [dpg_pkg::BANK_W-1:0] bank_select_inputs;
  logic [dpg_pkg::BYTE_W-1:0] byte_column_strobe_enables;
  logic write_enable;

  modport ctrl (
    input first_port_access_request, second_port_access_request, lock,
    input row_address_inputs, column_address_inputs, bank_select_inputs,
    input byte_column_strobe_enables, write_enable,
    output second_port_owner_flag, second_port_early_ack, first_port_ack
  );
  modport ports (
    output first_port_access_request, second_port_access_request, lock,
    output row_address_inputs, column_address_inputs, bank_select_inputs,
    output byte_column_strobe_enables, write_enable,
    input second_port_owner_flag, second_port_early_ack, first_port_ack
  );
endinterface
`default_nettype wire

//--- hdl/dpg_ports.sv
// port end: two CPU request sides muxed onto the shared inputs by the grant flag
`timescale 1ns/1ps
`default_nettype none
module dpg_ports (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  dpg_if.ports bus,
  input wire logic a_req_i,
  input wire logic a_lock_i,
  input wire logic [dpg_pkg::ROW_W-1:0] a_row_i,
  input wire logic [dpg_pkg::COL_W-1:0] a_col_i,
  input wire logic [dpg_pkg::BANK_W-1:0] a_bank_i,
  input wire logic [dpg_pkg::BYTE_W-1:0] a_be_i,
  input wire logic a_we_i,
  output logic a_wait_o,
  input wire logic b_req_i,
  input wire logic b_lock_i,
  input wire logic [dpg_pkg::ROW_W-1:0] b_row_i,
  input wire logic [dpg_pkg::COL_W-1:0] b_col_i,
  input wire logic [dpg_pkg::BANK_W-1:0] b_bank_i,
  input wire logic [dpg_pkg::BYTE_W-1:0] b_be_i,
  input wire logic b_we_i,
  output logic b_wait_o
);
  logic b_ack_q, b_ack_d;

  // both ports share this clock, so no request synchronizer is fitted
  assign bus.first_port_access_request = a_req_i;
  assign bus.second_port_access_request = b_req_i;
  // granted port's buffers drive the shared set, lock included
  assign bus.row_address_inputs = bus.second_port_owner_flag ? b_row_i : a_row_i;
  assign bus.column_address_inputs = bus.second_port_owner_flag ? b_col_i : a_col_i;
  assign bus.bank_select_inputs = bus.second_port_owner_flag ? b_bank_i : a_bank_i;
  assign bus.byte_column_strobe_enables = bus.second_port_owner_flag ? b_be_i : a_be_i;
  assign bus.write_enable = bus.second_port_owner_flag ? b_we_i : a_we_i;
  assign bus.lock = bus.second_port_owner_flag ? b_lock_i : a_lock_i;

  // registered ack copy stands in for the resync stage of an async CPU
  always_comb begin
    b_ack_d = bus.second_port_early_ack && b_req_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      b_ack_q <= 1'b0;
    end else if (clk_en_i) begin
      b_ack_q <= b_ack_d;
    end
  end

  assign a_wait_o = a_req_i && !bus.first_port_ack;
  assign b_wait_o = b_req_i && !b_ack_q;
endmodule
`default_nettype wire

//--- sim/dpg_monitor.sv
// checker: grant and acknowledge relations on the shared port bus
`timescale 1ns/1ps
`default_nettype none
module dpg_monitor (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic first_port_access_request,
  input wire logic second_port_access_request,
  input wire logic lock,
  input wire logic second_port_owner_flag,
  input wire logic second_port_early_ack,
  input wire logic first_port_ack
);
  wire ar = first_port_access_request;
  wire br = second_port_access_request;
  wire g = second_port_owner_flag;
  wire bk = second_port_early_ack;
  wire ak = first_port_ack;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_grant_to_b: assert property ($rose(g) |-> !$past(ar) && !$past(lock) && $past(br))
    else $error("grant moved to port B without cause");
  a_grant_to_a: assert property ($fell(g) |-> $past(ar) && !$past(lock))
    else $error("grant moved to port A without cause");
  a_lock_freeze: assert property ($past(lock) |-> $stable(g))
    else $error("grant moved while locked");
  a_b_lead: assert property ($rose(g) |-> ##[1:3] (bk || !br))
    else $error("port B access late after grant");
  a_b_owner: assert property ($rose(bk) |-> $past(g) && $past(br))
    else $error("port B ack without ownership");
  a_a_owner: assert property ($rose(ak) |-> !$past(g) && $past(ar))
    else $error("port A ack without ownership");
  a_b_ack_holds: assert property (bk ##1 br |-> bk)
    else $error("port B access cut short");
  a_a_ack_holds: assert property (ak ##1 ar |-> ak)
    else $error("port A access cut short");
  a_reset_grant: assert property ($fell(rst_i) |-> !g)
    else $error("port A not owner after reset");
endmodule
`default_nettype wire

//--- sim/tb_dual_port_dram_grant_lock.sv
// testbench: both ends joined, ports driven from the two CPU sides
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_dram_grant_lock;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ar = 1'b0, al = 1'b0, br = 1'b0, bl = 1'b0, rf = 1'b0;
  logic en = 1'h1;
  logic [28:0] va = 29'h0, vb = 29'h0;
  logic rbusy, rs, aw, bw, we;
  logic [10:0] ro, co;
  logic [1:0] bo;
  logic [3:0] be;
  int err_total = 0, compares = 0, cyc_n = 0;
  int q[$];
  dpg_if bus ();
  dpg_ctrl dpg_ctrl_i (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(en), .bus(bus), .refresh_req_i(rf),
    .refresh_busy_o(rbusy), .row_strobe_o(rs), .row_addr_o(ro), .col_addr_o(co), .bank_o(bo), .byte_en_o(be),
    .write_o(we));
  dpg_ports dpg_ports_i (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(en), .bus(bus), .a_req_i(ar),
    .a_lock_i(al), .a_row_i(va[10:0]), .a_col_i(va[21:11]), .a_bank_i(va[23:22]), .a_be_i(va[27:24]),
    .a_we_i(va[28]), .a_wait_o(aw), .b_req_i(br), .b_lock_i(bl), .b_row_i(vb[10:0]), .b_col_i(vb[21:11]),
    .b_bank_i(vb[23:22]), .b_be_i(vb[27:24]), .b_we_i(vb[28]), .b_wait_o(bw));
  dpg_monitor dpg_monitor_i (.clock_i(clock_i), .rst_i(rst_i),
    .first_port_access_request(bus.first_port_access_request),
    .second_port_access_request(bus.second_port_access_request), .lock(bus.lock),
    .second_port_owner_flag(bus.second_port_owner_flag), .second_port_early_ack(bus.second_port_early_ack),
    .first_port_ack(bus.first_port_ack));
  always #25 clock_i = ~clock_i;
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, far above the hundred or fewer cycles the tests need
  always @(posedge clock_i) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      err_total++;
      conclude();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  // waits for the strobe, then compares owner and the captured shared set
  task automatic acc(input logic gexp);
    int i;
    i = 0;
    while (rs !== 1'b1 && i < 20) begin
      cyc(1);
      i++;
    end
    chk("strobe", 32'h1, {31'h0, rs});
    chk("owner", {31'h0, gexp}, {31'h0, bus.second_port_owner_flag});
    chk("capture", q.pop_front(), {3'h0, we, be, bo, co, ro});
    // port A wait drops with the strobe, port B's one cycle later
    chk("wait at strobe", {31'h0, gexp}, {31'h0, gexp ? bw : aw});
  endtask
  initial begin
    int k;
    logic p;
    k = $urandom(62);
    cyc(4);
    rst_i = 1'b0;
    chk("reset owner", 32'h0, {31'h0, bus.second_port_owner_flag});
    $display("done reset");
    for (k = 0; k < 8; k++) begin
      p = 1'($urandom);
      va = 29'($urandom);
      vb = 29'($urandom);
      q.push_back(int'(p ? vb : va));
      if (p) br = 1'b1;
      else ar = 1'b1;
      acc(p);
      cyc(1);
      chk("wait released", 32'h0, {31'h0, p ? bw : aw});
      ar = 1'b0;
      br = 1'b0;
      cyc(3);
      chk("owner kept", {31'h0, p}, {31'h0, bus.second_port_owner_flag});
    end
    $display("done handover");
    br = 1'b1;
    bl = 1'b1;
    q.push_back(int'(vb));
    acc(1'b1);
    ar = 1'b1;
    cyc(4);
    chk("a waits", 32'h1, {31'h0, aw});
    br = 1'b0;
    cyc(4);
    chk("a locked out", 32'h1, {31'h0, aw});
    chk("lock holds owner", 32'h1, {31'h0, bus.second_port_owner_flag});
    rf = 1'b1;
    cyc(3);
    chk("refresh", 32'h1, {31'h0, rbusy});
    chk("locked owner", 32'h1, {31'h0, bus.second_port_owner_flag});
    rf = 1'b0;
    bl = 1'b0;
    q.push_back(int'(va));
    acc(1'b0);
    ar = 1'b0;
    cyc(2);
    $display("done lock");
    en = 1'h0;
    br = 1'h1;
    cyc(3);
    chk("frozen owner", 32'h0, {31'h0, bus.second_port_owner_flag});
    en = 1'h1;
    q.push_back(int'(vb));
    acc(1'h1);
    br = 1'h0;
    rst_i = 1'h1;
    cyc(2);
    rst_i = 1'h0;
    chk("reset owner again", 32'h0, {31'h0, bus.second_port_owner_flag});
    chk("reset strobe", 32'h0, {31'h0, rs});
    $display("done freeze and reset");
    conclude();
  end
endmodule
`default_nettype wire
